// >>> dual_clock_fifo_flag_modes_tb_top.sv
// Self-checking bench for both read timing modes of the flagged FIFO
`timescale 1ns/10ps
module dual_clock_fifo_flag_modes_tb_top;
  import fifo_flag_pkg::*;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic mode_sel = 1'b0;
  logic wr_req = 1'b0;
  logic rd_req = 1'b0;
  logic [DATA_W-1:0] wr_data = '0;
  logic write_enable_n, read_enable_n, empty_flag_n, full_flag_n, output_ready_n;
  logic input_ready_n, almost_empty_flag_n, half_level_flag_n, almost_full_flag_n;
  logic [DATA_W-1:0] data_in_a, data_out;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [REG_W-1:0] reg_wdata = '0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [REG_W-1:0] reg_rdata;
  logic [31:0] rng = 32'h0000_0035;
  logic [DATA_W-1:0] words[$];
  int fail_count = 0;
  int cmp_count = 0;
  int cnt, n_off, m_off;
  wire [6:0] flag_vec = {empty_flag_n, full_flag_n, output_ready_n, input_ready_n,
    almost_empty_flag_n, half_level_flag_n, almost_full_flag_n};

  flag_fifo dut (.clock, .reset_n, .fall_through_select(mode_sel), .write_enable_n,
    .data_in_a, .read_enable_n, .data_out, .empty_flag_n, .full_flag_n, .output_ready_n,
    .input_ready_n, .almost_empty_flag_n, .half_level_flag_n, .almost_full_flag_n,
    .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata);
  fifo_side_model side (.clock, .wr_req, .wr_data, .rd_req, .write_enable_n,
    .data_in_a, .read_enable_n);

  initial begin
    forever #2.5 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction : rnd
  // Fall-through counts include the output register word
  function automatic logic [6:0] exp_flags(input logic f, input int c);
    int t = f ? 1 : 0;
    return {f ? 1'b0 : c != 0, f ? 1'b1 : c < 512, f ? c == 0 : 1'b1,
      f ? c >= 513 : 1'b0, c >= n_off + 1 + t, c < 257 + t, c < 512 + t - m_off};
  endfunction : exp_flags
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic test_done();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done
  // Flags lag the count by their sync stages, so allow a bounded settle
  task automatic wait_flags(input logic f);
    for (int i = 0; i < 10; i++) begin
      @(posedge clock);
      #1;
      if (flag_vec === exp_flags(f, cnt)) break;
    end
    chk(flag_vec, exp_flags(f, cnt));
    if (flag_vec !== exp_flags(f, cnt)) test_done();
  endtask : wait_flags
  task automatic put(input logic [DATA_W-1:0] w);
    @(posedge clock);
    wr_req <= 1'b1;
    wr_data <= w;
    @(posedge clock);
    wr_req <= 1'b0;
  endtask : put
  task automatic take();
    @(posedge clock);
    rd_req <= 1'b1;
    @(posedge clock);
    rd_req <= 1'b0;
  endtask : take
  task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] e);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask : reg_rd
  ////////////////////////////////////////////////////////////////////////////////
  task automatic run_mode(input logic f);
    logic [DATA_W-1:0] w;
    int top;
    top = f ? 513 : 512;
    @(posedge clock);
    reset_n <= 1'b0;
    mode_sel <= f;
    repeat (10) @(posedge clock);
    reset_n <= 1'b1;
    #1;
    chk(flag_vec, 7'h33);
    reg_rd(ADDR_EMPTY_OFF, 32'h0000_007F);
    // Corner offsets in fall-through, random ones in standard
    n_off = f ? 511 : rnd() % 512;
    m_off = f ? 0 : rnd() % 512;
    reg_wr(ADDR_EMPTY_OFF, REG_W'(n_off));
    reg_wr(ADDR_FULL_OFF, REG_W'(m_off));
    reg_rd(ADDR_FULL_OFF, REG_W'(m_off));
    reg_rd(8'h0C, REG_ZERO);
    cnt = 0;
    for (int i = 0; i < top; i++) begin
      w = DATA_W'({rnd(), rnd(), rnd()});
      words.push_back(w);
      put(w);
      cnt++;
      if (f && i == 0) begin
        repeat (2) @(posedge clock);
        #1;
        chk(output_ready_n, 1'b1);
        @(posedge clock);
        #1;
        chk(output_ready_n, 1'b0);
        chk(data_out, w);
      end
      wait_flags(f);
    end
    put(~w);
    wait_flags(f);
    reg_rd(ADDR_STATUS, {15'h0000, f, 6'h00, 10'(top)});
    while (words.size() > 0) begin
      repeat (rnd() % 3) @(posedge clock);
      if (f) chk(data_out, words[0]);
      take();
      w = words.pop_front();
      cnt--;
      wait_flags(f);
      if (!f) chk(data_out, w);
    end
    take();
    wait_flags(f);
    if (!f) chk(data_out, w);
    reg_rd(ADDR_STATUS, {15'h0000, f, 16'h0000});
  endtask : run_mode

  initial begin
    run_mode(1'b0);
    run_mode(1'b1);
    test_done();
  end
endmodule : dual_clock_fifo_flag_modes_tb_top

// >>> fifo_flag_pkg.sv
// Constants, mode codes and flag carrier for the flagged FIFO
package fifo_flag_pkg;
  localparam int DATA_W = 72;
  localparam int DEPTH = 512;
  localparam int PTR_W = 9;
  localparam int CNT_W = 10;
  localparam int OFF_W = 9;
  localparam int ADDR_W = 8;
  localparam int REG_W = 32;
  localparam int STAT_MODE_BIT = 16;
  // Word-count thresholds
  localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;
  localparam logic [CNT_W-1:0] CNT_ONE = 10'h001;
  localparam logic [CNT_W-1:0] MEM_FULL = 10'h200;
  localparam logic [CNT_W-1:0] FALL_FULL = 10'h201;
  localparam logic [CNT_W-1:0] HF_STD = 10'h101;
  localparam logic [CNT_W-1:0] HF_FALL = 10'h102;
  localparam logic [CNT_W-1:0] PAE_STD_ADJ = 10'h001;
  localparam logic [CNT_W-1:0] PAE_FALL_ADJ = 10'h002;
  localparam logic [CNT_W-1:0] PAF_FALL_ADJ = 10'h001;
  localparam logic [PTR_W-1:0] PTR_ONE = 9'h001;
  localparam logic [OFF_W-1:0] DEF_OFFSET = 9'h07F;
  // Register map
  localparam logic [ADDR_W-1:0] ADDR_EMPTY_OFF = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_FULL_OFF = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h08;
  localparam logic [REG_W-1:0] REG_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    MODE_STANDARD = 2'b01,
    MODE_FALL = 2'b10
  } mode_t;

  typedef struct packed {
    logic almost_empty_n;
    logic half_n;
    logic almost_full_n;
  } level_flags_t;

  // Empty-buffer state: almost-empty low, half and almost-full high
  localparam level_flags_t LEVEL_RESET = 3'h3;
endpackage : fifo_flag_pkg

// >>> fifo_side_model.sv
// Writer and reader partner logic for the flagged FIFO
`timescale 1ns/10ps
module fifo_side_model (
  input wire logic clock,
  input wire logic wr_req,
  input wire logic [fifo_flag_pkg::DATA_W-1:0] wr_data,
  input wire logic rd_req,
  output logic write_enable_n,
  output logic [fifo_flag_pkg::DATA_W-1:0] data_in_a,
  output logic read_enable_n
);
  import fifo_flag_pkg::*;
  logic [DATA_W-1:0] last_ff = '0;
  always_ff @(posedge clock) begin
    if (wr_req) begin
      last_ff <= wr_data;
    end
  end
  assign write_enable_n = ~wr_req;
  // Idle bus shows the inverse, so a stale capture cannot match
  assign data_in_a = wr_req ? wr_data : ~last_ff;
  // Every word is asked for, the first too in standard timing
  assign read_enable_n = ~rd_req;
endmodule : fifo_side_model

// >>> flag_fifo.sv
// Flagged FIFO with standard and fall-through read timing
`timescale 1ns/10ps
//
// Contract
// - Mode pin sampled during reset, held stable
// - Fall-through: first word shows after three edges
// - Write enable low captures data each edge
// - Standard: empty flag rises after first write
// - Standard: almost-empty high at n+1 words
// - Standard: half flag low above half depth
// - Standard: almost-full low at depth minus m
// - Standard: full after D writes, writes ignored
// - First read from full releases full indication
// - Standard: almost-empty low when count reaches n
// - Standard: empty after last read, reads ignored
// - Standard: empty and full flags two stages
// - Fall-through: output-ready low once word shown
// - Fall-through: almost-empty high at n+2 words
// - Fall-through: half flag one word later
// - Fall-through: almost-full low at D+1-m
// - Fall-through: input-ready high at D+1, writes ignored
// - Fall-through: almost-empty low at n+1 words
// - Fall-through: output-ready high after last read
// - Output-ready three stages, input-ready two stages
module flag_fifo (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic fall_through_select,
  input wire logic write_enable_n,
  input wire logic [fifo_flag_pkg::DATA_W-1:0] data_in_a,
  input wire logic read_enable_n,
  output logic [fifo_flag_pkg::DATA_W-1:0] data_out,
  output logic empty_flag_n,
  output logic full_flag_n,
  output logic output_ready_n,
  output logic input_ready_n,
  output logic almost_empty_flag_n,
  output logic half_level_flag_n,
  output logic almost_full_flag_n,
  input wire logic [fifo_flag_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [fifo_flag_pkg::REG_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [fifo_flag_pkg::REG_W-1:0] reg_rdata
);
  import fifo_flag_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  logic [DATA_W-1:0] mem [DEPTH];
  mode_t mode_ff;
  logic [PTR_W-1:0] wr_ptr_ff;
  logic [PTR_W-1:0] rd_ptr_ff;
  logic [CNT_W-1:0] mem_cnt_ff;
  logic [CNT_W-1:0] nxt_mem_cnt;
  logic [CNT_W-1:0] total_cnt;
  logic out_valid_ff;
  logic nxt_out_valid;
  logic avail_s1_ff;
  logic avail_s2_ff;
  logic [DATA_W-1:0] data_out_ff;
  logic ef_s1_ff;
  logic empty_ff;
  logic ff_s1_ff;
  logic full_ff;
  logic ir_s1_ff;
  logic ir_ff;
  logic or_ff;
  level_flags_t level_ff;
  logic [OFF_W-1:0] empty_off_ff;
  logic [OFF_W-1:0] full_off_ff;
  logic [REG_W-1:0] rdata_ff;
  logic is_fall;
  logic push;
  logic pop;
  logic wr_open;
  logic [CNT_W-1:0] pae_level;
  logic [CNT_W-1:0] hf_level;
  logic [CNT_W-1:0] paf_level;

  assign is_fall = (mode_ff == MODE_FALL);

  ////////////////////////////////////////////////////////////////////////
  // Mode strap, caught while reset is low
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      mode_ff <= fall_through_select ? MODE_FALL : MODE_STANDARD;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Accept and pop decisions
  always_comb begin
    // Gate on the visible flag so a write the writer saw refused is refused
    wr_open = is_fall ? !ir_ff : full_ff;
    push = !write_enable_n && wr_open && (mem_cnt_ff < MEM_FULL);
    if (is_fall) begin
      // Reload the output word when it is empty or being taken
      pop = (mem_cnt_ff != CNT_ZERO) && avail_s2_ff &&
            (!out_valid_ff || !read_enable_n);
    end else begin
      pop = !read_enable_n && empty_ff && (mem_cnt_ff != CNT_ZERO);
    end
    if (!is_fall) begin
      nxt_out_valid = 1'b0;
    end else if (pop) begin
      nxt_out_valid = 1'b1;
    end else if (!read_enable_n) begin
      nxt_out_valid = 1'b0;
    end else begin
      nxt_out_valid = out_valid_ff;
    end
    case ({push, pop})
      2'b10: nxt_mem_cnt = mem_cnt_ff + CNT_ONE;
      2'b01: nxt_mem_cnt = mem_cnt_ff - CNT_ONE;
      default: nxt_mem_cnt = mem_cnt_ff;
    endcase
  end

  // The output register counts as one more stored word in fall-through
  assign total_cnt = is_fall ? mem_cnt_ff + {{(CNT_W-1){1'b0}}, out_valid_ff}
                             : mem_cnt_ff;

  ////////////////////////////////////////////////////////////////////////
  // Storage and pointers
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr_ff] <= data_in_a;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      mem_cnt_ff <= CNT_ZERO;
      out_valid_ff <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + PTR_ONE;
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + PTR_ONE;
      end
      mem_cnt_ff <= nxt_mem_cnt;
      out_valid_ff <= nxt_out_valid;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      data_out_ff <= '0;
    end else if (pop) begin
      data_out_ff <= mem[rd_ptr_ff];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Staged empty/full style flags; stale stages only delay, never overrun
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      avail_s1_ff <= 1'b0;
      avail_s2_ff <= 1'b0;
      ef_s1_ff <= 1'b0;
      empty_ff <= 1'b0;
      ff_s1_ff <= 1'b1;
      full_ff <= 1'b1;
      ir_s1_ff <= 1'b0;
      ir_ff <= 1'b0;
      or_ff <= 1'b1;
    end else begin
      avail_s1_ff <= (mem_cnt_ff != CNT_ZERO);
      avail_s2_ff <= avail_s1_ff;
      ef_s1_ff <= !is_fall && (mem_cnt_ff != CNT_ZERO);
      empty_ff <= ef_s1_ff;
      ff_s1_ff <= is_fall || (mem_cnt_ff != MEM_FULL);
      full_ff <= ff_s1_ff;
      ir_s1_ff <= is_fall && (total_cnt == FALL_FULL);
      ir_ff <= ir_s1_ff;
      or_ff <= !nxt_out_valid;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Level flags, thresholds shift by one word in fall-through
  always_comb begin
    pae_level = {1'b0, empty_off_ff} + (is_fall ? PAE_FALL_ADJ : PAE_STD_ADJ);
    hf_level = is_fall ? HF_FALL : HF_STD;
    paf_level = MEM_FULL - {1'b0, full_off_ff} + (is_fall ? PAF_FALL_ADJ : CNT_ZERO);
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      level_ff <= LEVEL_RESET;
    end else begin
      level_ff.almost_empty_n <= (total_cnt >= pae_level);
      level_ff.half_n <= (total_cnt < hf_level);
      level_ff.almost_full_n <= (total_cnt < paf_level);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Offset and status registers; software keeps offsets below depth
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      empty_off_ff <= DEF_OFFSET;
      full_off_ff <= DEF_OFFSET;
    end else if (reg_write) begin
      if (reg_addr == ADDR_EMPTY_OFF) begin
        empty_off_ff <= reg_wdata[OFF_W-1:0];
      end
      if (reg_addr == ADDR_FULL_OFF) begin
        full_off_ff <= reg_wdata[OFF_W-1:0];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      rdata_ff <= REG_ZERO;
    end else if (reg_read) begin
      case (reg_addr)
        ADDR_EMPTY_OFF: rdata_ff <= {{(REG_W-OFF_W){1'b0}}, empty_off_ff};
        ADDR_FULL_OFF: rdata_ff <= {{(REG_W-OFF_W){1'b0}}, full_off_ff};
        ADDR_STATUS: begin
          rdata_ff <= {{(REG_W-CNT_W){1'b0}}, total_cnt};
          rdata_ff[STAT_MODE_BIT] <= is_fall;
        end
        default: rdata_ff <= REG_ZERO;
      endcase
    end else begin
      rdata_ff <= REG_ZERO;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign data_out = data_out_ff;
  assign empty_flag_n = empty_ff;
  assign full_flag_n = full_ff;
  assign output_ready_n = or_ff;
  assign input_ready_n = ir_ff;
  assign almost_empty_flag_n = level_ff.almost_empty_n;
  assign half_level_flag_n = level_ff.half_n;
  assign almost_full_flag_n = level_ff.almost_full_n;
  assign reg_rdata = rdata_ff;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  a_mode_held: assert property ($past(reset_n) |-> $stable(mode_ff))
    else $error("mode changed outside reset");

  a_full_refuses: assert property (
    (!is_fall && !full_flag_n && !pop) |=> mem_cnt_ff == $past(mem_cnt_ff))
    else $error("write taken while full");

  a_empty_ignores: assert property (
    (mem_cnt_ff == CNT_ZERO && !push) |=> mem_cnt_ff == CNT_ZERO)
    else $error("read taken while empty");

  a_empty_two_stage: assert property (
    (!is_fall && mem_cnt_ff != CNT_ZERO)[*2] |=> empty_flag_n)
    else $error("empty flag not released two edges after data");

  a_full_two_stage: assert property (
    (!is_fall && mem_cnt_ff == MEM_FULL)[*2] |=> !full_flag_n)
    else $error("full flag not set two edges after full");

  a_first_fall: assert property (
    (is_fall && !out_valid_ff && mem_cnt_ff == CNT_ZERO && push) |-> ##4 !output_ready_n)
    else $error("first word did not fall through on third edge");

  a_ir_two_stage: assert property (
    (is_fall && total_cnt == FALL_FULL)[*2] |=> input_ready_n)
    else $error("input ready not raised at depth plus one");

  a_half_level: assert property (
    (total_cnt >= hf_level) |=> !half_level_flag_n)
    else $error("half flag not low above half depth");

  a_almost_full: assert property (
    $stable(full_off_ff) && (total_cnt >= paf_level) |=> !almost_full_flag_n)
    else $error("almost full flag not low at threshold");

  a_almost_empty: assert property (
    $stable(empty_off_ff) && (total_cnt < pae_level) |=> !almost_empty_flag_n)
    else $error("almost empty flag not low below threshold");

  a_or_tracks: assert property (
    is_fall && !read_enable_n && !output_ready_n && mem_cnt_ff == CNT_ZERO
    |=> output_ready_n)
    else $error("output ready not released after last read");

  a_reset_state: assert property (
    !$past(reset_n) |-> !empty_flag_n && full_flag_n && output_ready_n && !input_ready_n &&
    level_ff == LEVEL_RESET && mem_cnt_ff == CNT_ZERO && data_out == '0)
    else $error("flags not in empty state after reset");

  a_std_flags_idle: assert property (
    !is_fall |-> output_ready_n && !input_ready_n)
    else $error("fall-through flags active in standard mode");

  a_fall_flags_idle: assert property (
    is_fall |-> !empty_flag_n && full_flag_n)
    else $error("standard flags active in fall-through mode");

  a_std_read_hold: assert property (
    !is_fall && read_enable_n |=> $stable(data_out))
    else $error("output word changed without a read");

  a_fall_word_hold: assert property (
    is_fall && !output_ready_n && read_enable_n |=> !output_ready_n && $stable(data_out))
    else $error("shown word dropped without a read");

  a_write_counts: assert property (
    push && !pop |=> mem_cnt_ff == $past(mem_cnt_ff) + CNT_ONE)
    else $error("accepted write not counted");

  a_empty_low: assert property (
    (!is_fall && mem_cnt_ff == CNT_ZERO)[*2] |=> !empty_flag_n)
    else $error("empty flag not set two edges after last read");

  a_full_release: assert property (
    !is_fall && !full_flag_n && pop |-> ##3 full_flag_n)
    else $error("full flag not released after first read");

  a_ir_release: assert property (
    is_fall && input_ready_n && !output_ready_n && !read_enable_n |-> ##3 !input_ready_n)
    else $error("input ready not released after first read");

  a_half_release: assert property (
    (total_cnt < hf_level) |=> half_level_flag_n)
    else $error("half flag not released below half depth");

  a_pae_rise_std: assert property (
    !is_fall && (total_cnt >= {1'b0, empty_off_ff} + PAE_STD_ADJ) |=> almost_empty_flag_n)
    else $error("almost empty flag not high at n plus one");

  a_pae_rise_fall: assert property (
    is_fall && (total_cnt >= {1'b0, empty_off_ff} + PAE_FALL_ADJ) |=> almost_empty_flag_n)
    else $error("almost empty flag not high at n plus two");

  a_pae_fall_low: assert property (
    is_fall && (total_cnt < {1'b0, empty_off_ff} + PAE_FALL_ADJ) |=> !almost_empty_flag_n)
    else $error("almost empty flag not low at n plus one");

  a_half_fall: assert property (
    is_fall && (total_cnt >= HF_FALL) |=> !half_level_flag_n)
    else $error("half flag not low one word later");

  a_paf_fall: assert property (
    is_fall && (total_cnt >= MEM_FULL + PAF_FALL_ADJ - {1'b0, full_off_ff})
    |=> !almost_full_flag_n)
    else $error("almost full flag not low at depth plus one minus m");

  a_or_shows: assert property (
    is_fall && pop |=> !output_ready_n)
    else $error("output ready not set when word shown");

  a_avail_stages: assert property (
    is_fall && mem_cnt_ff == CNT_ZERO |-> ##2 !avail_s2_ff)
    else $error("availability not staged through two flops");

  a_empty_refuses: assert property (
    !is_fall && !empty_flag_n |=> $stable(data_out))
    else $error("read taken while empty flag low");

  a_fall_read_ignored: assert property (
    is_fall && output_ready_n && mem_cnt_ff == CNT_ZERO |=> output_ready_n && $stable(data_out))
    else $error("read taken while output ready high");

  a_ir_refuses: assert property (
    is_fall && input_ready_n && !pop |=> mem_cnt_ff == $past(mem_cnt_ff))
    else $error("write taken while input ready high");
endmodule : flag_fifo
